// ==== mmx_pkg.sv ====
package mmx_pkg;

    // ********************************************************
    // Channel counts and sample format
    // ********************************************************
    localparam int N_IN = 16;
    localparam int N_PB = 16;
    localparam int N_SRC = 32;
    localparam int N_OUT = 16;
    localparam int N_PAIR = 8;
    localparam int SW = 24;
    localparam int GW = 8;
    localparam int MS_W = 32;

    // ********************************************************
    // Gain and pan scaling, reset values
    // ********************************************************
    localparam logic [GW-1:0] GAIN_RST = 8'h00;
    localparam logic [GW-1:0] PAN_RST = 8'h80;
    localparam logic [GW-1:0] OGAIN_RST = 8'h80;
    localparam logic [GW-1:0] PAN_FULL = 8'hFF;
    localparam int GAIN_SH = 7;
    localparam int PAN_SH = 8;

    // ********************************************************
    // Configuration port selectors
    // ********************************************************
    localparam logic [1:0] SEL_GAIN = 2'h0;
    localparam logic [1:0] SEL_PAN = 2'h1;
    localparam logic [1:0] SEL_OGAIN = 2'h2;

    // ********************************************************
    // Schedule and meter timing
    // ********************************************************
    localparam logic [7:0] IDX_LAST = 8'hFF;
    localparam logic [4:0] SRC_LAST = 5'h1F;
    localparam int MIX_LATENCY = 258;
    localparam int PEAK_DECAY_SH = 12;
    localparam int RMS_SH = 12;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } mmx_state_t;

endpackage : mmx_pkg

// ==== mmx_meter.sv ====
`timescale 1ns/100ps
`default_nettype none
module mmx_meter #(
    parameter bit HAS_RMS = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic smp_valid,
    input wire logic [mmx_pkg::SW-1:0] smp,
    output logic [mmx_pkg::SW-1:0] peak,
    output logic [mmx_pkg::MS_W-1:0] ms
);
    import mmx_pkg::*;

    typedef struct packed {
        logic [SW-1:0] peak;
        logic [MS_W-1:0] ms;
    } mmx_meter_regs_t;

    mmx_meter_regs_t st_r;
    mmx_meter_regs_t st_nxt;
    logic [SW-1:0] mag;
    logic [MS_W-1:0] sq;
    logic signed [MS_W:0] diff;
    logic [SW-1:0] dec;

    assign mag = smp[SW-1] ? SW'(~smp + 24'h000001) : smp;
    // Widen first, a 16-bit product would lose the square
    assign sq = {16'h0000, mag[SW-1:8]} * {16'h0000, mag[SW-1:8]};
    assign dec = st_r.peak - (st_r.peak >> PEAK_DECAY_SH) - SW'(st_r.peak != '0);
    assign diff = $signed({1'b0, sq}) - $signed({1'b0, st_r.ms});

    // ********************************************************
    // Peak and mean-square update
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        if (smp_valid) begin
            if (mag >= st_r.peak) begin
                st_nxt.peak = mag;
            end else begin
                // Slow release; never below the sample now present
                st_nxt.peak = (dec > mag) ? dec : mag;
            end
            if (HAS_RMS) begin
                st_nxt.ms = MS_W'($signed({1'b0, st_r.ms}) + (diff >>> RMS_SH));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign peak = st_r.peak;
    assign ms = st_r.ms;

    // ********************************************************
    // Checks
    // ********************************************************
    property p_peak_attack;
        @(posedge clk) disable iff (rst)
        smp_valid && (mag >= peak) |=> peak == $past(mag);
    endproperty
    a_peak_attack: assert property (p_peak_attack) else $error("peak missed a sample");

    property p_peak_release;
        @(posedge clk) disable iff (rst)
        smp_valid && (mag < peak) |=> (peak < $past(peak)) && (peak >= $past(mag));
    endproperty
    a_peak_release: assert property (p_peak_release) else $error("peak release wrong");

endmodule : mmx_meter
`default_nettype wire

// ==== mmx_mixer.sv ====
`timescale 1ns/100ps
`default_nettype none
module mmx_mixer (
    input wire logic clk,
    input wire logic rst,
    input wire logic smp_valid,
    input wire logic [mmx_pkg::N_IN-1:0][mmx_pkg::SW-1:0] in_smp,
    input wire logic [mmx_pkg::N_PB-1:0][mmx_pkg::SW-1:0] pb_smp,
    input wire logic [mmx_pkg::N_OUT-1:0] loopback,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [2:0] cfg_pair,
    input wire logic [4:0] cfg_src,
    input wire logic [mmx_pkg::GW-1:0] cfg_val,
    output logic [mmx_pkg::N_OUT-1:0][mmx_pkg::SW-1:0] out_smp,
    output logic [mmx_pkg::N_IN-1:0][mmx_pkg::SW-1:0] rec_smp,
    output logic out_valid,
    output logic busy,
    output logic [mmx_pkg::N_SRC-1:0][mmx_pkg::SW-1:0] src_peak,
    output logic [mmx_pkg::N_SRC-1:0][mmx_pkg::MS_W-1:0] src_ms,
    output logic [mmx_pkg::N_OUT-1:0][mmx_pkg::SW-1:0] out_peak
);
    import mmx_pkg::*;

    typedef struct packed {
        mmx_state_t st;
        logic [7:0] idx;
        logic signed [31:0] acc_l;
        logic signed [31:0] acc_r;
        logic [N_SRC-1:0][SW-1:0] src;
        logic [N_PAIR-1:0][N_SRC-1:0][GW-1:0] gain;
        logic [N_PAIR-1:0][N_SRC-1:0][GW-1:0] pan;
        logic [N_OUT-1:0][GW-1:0] ogain;
        logic [N_OUT-1:0][SW-1:0] out;
        logic [N_IN-1:0][SW-1:0] rec;
        logic out_valid;
    } mmx_regs_t;

    mmx_regs_t st_r;
    mmx_regs_t st_nxt;

    function automatic logic [SW-1:0] mmx_sat(input logic signed [41:0] v);
        if (v > 42'sh7FFFFF) begin
            return 24'h7FFFFF;
        end else if (v < -42'sh800000) begin
            return 24'h800000;
        end else begin
            return v[SW-1:0];
        end
    endfunction : mmx_sat

    // ********************************************************
    // Mixing schedule and settings
    // ********************************************************
    always_comb begin
        logic [4:0] s;
        logic [2:0] pr;
        logic [3:0] ol;
        logic [3:0] orr;
        logic signed [41:0] prod_l;
        logic signed [41:0] prod_r;
        logic signed [31:0] sum_l;
        logic signed [31:0] sum_r;
        s = st_r.idx[4:0];
        pr = st_r.idx[7:5];
        ol = {pr, 1'b0};
        orr = {pr, 1'b1};
        prod_l = '0;
        prod_r = '0;
        sum_l = '0;
        sum_r = '0;
        st_nxt = st_r;
        st_nxt.out_valid = 1'b0;

        // Settings take effect from the next cycle, even partway through a running mix
        if (cfg_wr) begin
            case (cfg_sel)
                SEL_GAIN: st_nxt.gain[cfg_pair][cfg_src] = cfg_val;
                SEL_PAN: st_nxt.pan[cfg_pair][cfg_src] = cfg_val;
                SEL_OGAIN: st_nxt.ogain[cfg_src[3:0]] = cfg_val;
                default: st_nxt.gain = st_r.gain;
            endcase
        end

        case (st_r.st)
            ST_IDLE: begin
                st_nxt.idx = '0;
                if (smp_valid) begin
                    st_nxt.src = {pb_smp, in_smp};
                    st_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // One multiply-add per source and pair: 256 cycles a sample
                prod_l = $signed(st_r.src[s]) * $signed({1'b0, st_r.gain[pr][s]})
                    * $signed({1'b0, PAN_FULL - st_r.pan[pr][s]});
                prod_r = $signed(st_r.src[s]) * $signed({1'b0, st_r.gain[pr][s]})
                    * $signed({1'b0, st_r.pan[pr][s]});
                sum_l = ((s == '0) ? 32'sh0 : st_r.acc_l)
                    + 32'(prod_l >>> (GAIN_SH + PAN_SH));
                sum_r = ((s == '0) ? 32'sh0 : st_r.acc_r)
                    + 32'(prod_r >>> (GAIN_SH + PAN_SH));
                st_nxt.acc_l = sum_l;
                st_nxt.acc_r = sum_r;
                if (s == SRC_LAST) begin
                    st_nxt.out[ol] = mmx_sat((42'(sum_l)
                        * $signed({1'b0, st_r.ogain[ol]})) >>> GAIN_SH);
                    st_nxt.out[orr] = mmx_sat((42'(sum_r)
                        * $signed({1'b0, st_r.ogain[orr]})) >>> GAIN_SH);
                end
                st_nxt.idx = st_r.idx + 8'h01;
                if (st_r.idx == IDX_LAST) begin
                    st_nxt.st = ST_DONE;
                end
            end
            ST_DONE: begin
                for (int k = 0; k < N_IN; k++) begin
                    st_nxt.rec[k] = loopback[k] ? st_r.out[k] : st_r.src[k];
                end
                st_nxt.out_valid = 1'b1;
                st_nxt.st = ST_IDLE;
            end
            default: st_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.st <= ST_IDLE;
            st_r.pan <= {(N_PAIR * N_SRC){PAN_RST}};
            st_r.gain <= {(N_PAIR * N_SRC){GAIN_RST}};
            st_r.ogain <= {N_OUT{OGAIN_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_smp = st_r.out;
    assign rec_smp = st_r.rec;
    assign out_valid = st_r.out_valid;
    assign busy = (st_r.st != ST_IDLE);

    // ********************************************************
    // Level meters
    // ********************************************************
    for (genvar i = 0; i < N_SRC; i++) begin : g_src_mtr
        mmx_meter #(.HAS_RMS(1'b1)) u_mtr (
            .clk(clk),
            .rst(rst),
            .smp_valid(smp_valid),
            .smp((i < N_IN) ? in_smp[i % N_IN] : pb_smp[i % N_PB]),
            .peak(src_peak[i]),
            .ms(src_ms[i])
        );
    end
    for (genvar i = 0; i < N_OUT; i++) begin : g_out_mtr
        mmx_meter #(.HAS_RMS(1'b0)) u_mtr (
            .clk(clk),
            .rst(rst),
            .smp_valid(st_r.out_valid),
            .smp(st_r.out[i]),
            .peak(out_peak[i]),
            .ms()
        );
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_latency;
        @(posedge clk) disable iff (rst)
        smp_valid && (st_r.st == ST_IDLE) |-> ##258 out_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("mix latency wrong");

    sequence s_run_end;
        (st_r.st == ST_RUN) && (st_r.idx == IDX_LAST);
    endsequence
    property p_all_pairs;
        @(posedge clk) disable iff (rst)
        s_run_end |=> (st_r.st == ST_DONE) ##1 out_valid;
    endproperty
    a_all_pairs: assert property (p_all_pairs) else $error("mix pass incomplete");

    property p_rec_bypass;
        @(posedge clk) disable iff (rst)
        out_valid && !$past(loopback[0]) |-> rec_smp[0] == $past(in_smp[0], 258);
    endproperty
    a_rec_bypass: assert property (p_rec_bypass) else $error("record path altered");

    property p_rec_loop;
        @(posedge clk) disable iff (rst)
        out_valid && $past(loopback[0]) |-> rec_smp[0] == out_smp[0];
    endproperty
    a_rec_loop: assert property (p_rec_loop) else $error("loopback not returned");

    property p_out_mute;
        @(posedge clk) disable iff (rst)
        out_valid && (st_r.ogain[0] == '0) && $stable(st_r.ogain[0]) |-> out_smp[0] == '0;
    endproperty
    a_out_mute: assert property (p_out_mute) else $error("output gain ignored");

    property p_src_meter;
        @(posedge clk) disable iff (rst)
        smp_valid && (in_smp[0] == 24'h800000) |=> src_peak[0] == 24'h800000;
    endproperty
    a_src_meter: assert property (p_src_meter) else $error("input meter not pre-fader");

    property p_out_meter;
        @(posedge clk) disable iff (rst)
        out_valid && (out_smp[2] == 24'h7FFFFF) |=> out_peak[2] == 24'h7FFFFF;
    endproperty
    a_out_meter: assert property (p_out_meter) else $error("output meter missed peak");

    property p_idle_reset;
        @(posedge clk) disable iff (rst)
        (st_r.st == ST_IDLE) && !smp_valid |=> (st_r.idx == '0) && !busy;
    endproperty
    a_idle_reset: assert property (p_idle_reset) else $error("schedule not parked");

    property p_pan_hard_left;
        @(posedge clk) disable iff (rst)
        (st_r.st == ST_RUN) && (st_r.pan[st_r.idx[7:5]][st_r.idx[4:0]] == '0)
            && (st_r.idx[4:0] == '0) |=> st_r.acc_r == '0;
    endproperty
    a_pan_hard_left: assert property (p_pan_hard_left) else $error("pan leaks right");

endmodule : mmx_mixer
`default_nettype wire

// ==== mmx_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module mmx_host (
    input wire logic clk,
    input wire logic frame_en,
    input wire logic [mmx_pkg::N_PB-1:0][mmx_pkg::SW-1:0] pb_data,
    output logic [mmx_pkg::N_PB-1:0][mmx_pkg::SW-1:0] pb_smp,
    input wire logic out_valid,
    input wire logic [mmx_pkg::N_IN-1:0][mmx_pkg::SW-1:0] rec_smp,
    output logic [mmx_pkg::N_IN-1:0][mmx_pkg::SW-1:0] rec_last
);
    import mmx_pkg::*;
    // Inverse outside a frame, so stale playback never looks valid
    assign pb_smp = frame_en ? pb_data : ~pb_data;
    // Record capture only on the valid pulse, as the host would
    always @(posedge clk) begin
        if (out_valid === 1'b1) begin
            rec_last <= rec_smp;
        end
    end
endmodule : mmx_host
`default_nettype wire

// ==== tb_matrix_mixer_with_metering.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_matrix_mixer_with_metering;
    import mmx_pkg::*;
    logic clk;
    logic rst;
    logic smp_valid;
    logic cfg_wr;
    logic [1:0] cfg_sel;
    logic [2:0] cfg_pair;
    logic [4:0] cfg_src;
    logic [GW-1:0] cfg_val;
    logic [N_OUT-1:0] loopback;
    logic [N_IN-1:0][SW-1:0] in_smp;
    logic [N_PB-1:0][SW-1:0] pb_data;
    logic [N_PB-1:0][SW-1:0] pb_smp;
    logic [N_OUT-1:0][SW-1:0] out_smp;
    logic [N_IN-1:0][SW-1:0] rec_smp;
    logic [N_IN-1:0][SW-1:0] rec_last;
    logic [N_SRC-1:0][SW-1:0] src_peak;
    logic [N_SRC-1:0][MS_W-1:0] src_ms;
    logic [N_OUT-1:0][SW-1:0] out_peak;
    logic out_valid;
    logic busy;
    logic frame_en;
    int n_fail;
    int checks_done;
    int lat;
    int extra;
    mmx_mixer u_dut (
        .clk(clk), .rst(rst), .smp_valid(smp_valid), .in_smp(in_smp),
        .pb_smp(pb_smp), .loopback(loopback), .cfg_wr(cfg_wr),
        .cfg_sel(cfg_sel), .cfg_pair(cfg_pair), .cfg_src(cfg_src),
        .cfg_val(cfg_val), .out_smp(out_smp), .rec_smp(rec_smp),
        .out_valid(out_valid), .busy(busy), .src_peak(src_peak),
        .src_ms(src_ms), .out_peak(out_peak)
    );
    mmx_host u_host (
        .clk(clk), .frame_en(frame_en), .pb_data(pb_data), .pb_smp(pb_smp),
        .out_valid(out_valid), .rec_smp(rec_smp), .rec_last(rec_last)
    );
    // ****
    // Helpers
    // ****
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // Sum is truncated once, then output gain, then clipped to 24 bits
    function automatic logic [23:0] mx(input longint acc, input longint og);
        longint v;
        v = ((acc >>> 15) * og) >>> 7;
        if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
        if (v < -64'sh800000) v = -64'sh800000;
        return v[23:0];
    endfunction : mx
    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        in_smp = '0;
        pb_data = '0;
        loopback = '0;
        @(negedge clk);
    endtask : do_reset
    task automatic cfg(input logic [1:0] sel, input int p, input int s, input logic [7:0] v);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_sel = sel;
        cfg_pair = 3'(p);
        cfg_src = 5'(s);
        cfg_val = v;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg
    task automatic route(input int p, input int s, input logic [7:0] g, input logic [7:0] pan);
        cfg(SEL_GAIN, p, s, g);
        cfg(SEL_PAN, p, s, pan);
    endtask : route
    // Poke raises a second frame mid-mix; it must not start a mix
    task automatic run_frame(input bit poke);
        @(negedge clk);
        smp_valid = 1'b1;
        frame_en = 1'b1;
        @(negedge clk);
        smp_valid = 1'b0;
        frame_en = 1'b0;
        chk("busy", busy, 1);
        // Counted from the taking edge to the edge that sees out_valid
        lat = 1;
        while (out_valid !== 1'b1 && lat < 400) begin
            @(negedge clk);
            lat++;
            smp_valid = poke && lat == 10;
            frame_en = poke && lat == 10;
        end
        chk("latency", lat, MIX_LATENCY);
        extra = 0;
        repeat (12) begin
            @(negedge clk);
            extra += (out_valid === 1'b1);
        end
        chk("extra_valid", extra, 0);
    endtask : run_frame
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        do_reset();
        chk("busy_rst", busy, 0);
        chk("peak_rst", src_peak[0], 0);
        route(0, 0, 8'h80, 8'h80);
        cfg(SEL_OGAIN, 0, 0, 8'h00);
        in_smp[0] = 24'h100000;
        run_frame(0);
        chk("out_nogain", out_smp[2], 0);
        chk("out_mute", out_smp[0], 0);
        chk("out_center", out_smp[1], mx(64'sh100000 * 128 * 128, 128));
        chk("rec_plain", rec_last[0], 24'h100000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_route();
        do_reset();
        route(0, 0, 8'h80, 8'h00);
        route(3, 0, 8'h40, 8'hFF);
        route(0, 16, 8'h80, 8'hFF);
        in_smp[0] = 24'h100000;
        in_smp[5] = 24'h123456;
        pb_data[0] = 24'h080000;
        run_frame(0);
        chk("out0", out_smp[0], mx(64'sh100000 * 128 * 255, 128));
        chk("out1", out_smp[1], mx(64'sh080000 * 128 * 255, 128));
        chk("out6", out_smp[6], 0);
        chk("out7", out_smp[7], mx(64'sh100000 * 64 * 255, 128));
        chk("out2", out_smp[2], 0);
        chk("rec5", rec_last[5], 24'h123456);
        chk("peak_in0", src_peak[0], 24'h100000);
        chk("peak_pb0", src_peak[16], 24'h080000);
        chk("ms_live", src_ms[0] != 0, 1);
        chk("opeak0", out_peak[0], mx(64'sh100000 * 128 * 255, 128));
        in_smp[0] = 24'h000000;
        run_frame(0);
        chk("peak_hold", src_peak[0], 24'h0FFEFF);
        chk("opeak_hold", out_peak[0], 24'h0FEF00);
        $display("test route done");
    endtask : t_route
    task automatic t_pairs();
        do_reset();
        for (int p = 0; p < 8; p++) begin
            route(p, 2 * p + 1, 8'h80, 8'h00);
            in_smp[2 * p + 1] = 24'((p + 1) << 16);
        end
        route(7, 31, 8'h80, 8'hFF);
        pb_data[15] = 24'h080000;
        in_smp[0] = 24'h800000;
        run_frame(0);
        chk("peak_min", src_peak[0], 24'h800000);
        for (int p = 0; p < 7; p++) begin
            chk("pair_l", out_smp[2 * p], mx(longint'(p + 1) * 65536 * 128 * 255, 128));
            chk("pair_r", out_smp[2 * p + 1], 0);
        end
        chk("out14", out_smp[14], mx(64'sh080000 * 128 * 255, 128));
        chk("out15", out_smp[15], mx(64'sh080000 * 128 * 255, 128));
        chk("peak31", src_peak[31], 24'h080000);
        $display("test pairs done");
    endtask : t_pairs
    task automatic t_sat();
        do_reset();
        route(1, 2, 8'hFF, 8'h00);
        route(1, 3, 8'hFF, 8'h00);
        route(2, 4, 8'h80, 8'h00);
        route(0, 0, 8'h80, 8'h00);
        cfg(SEL_OGAIN, 0, 0, 8'h40);
        in_smp[0] = 24'h100000;
        in_smp[2] = 24'h400000;
        in_smp[3] = 24'h7FFFFF;
        in_smp[4] = 24'hC00000;
        loopback = 16'h0011;
        run_frame(1);
        chk("sat2", out_smp[2], 24'h7FFFFF);
        chk("neg4", out_smp[4], mx(-64'sh400000 * 128 * 255, 128));
        chk("ogain0", out_smp[0], mx(64'sh100000 * 128 * 255, 64));
        chk("loop0", rec_last[0], mx(64'sh100000 * 128 * 255, 64));
        chk("loop4", rec_last[4], mx(-64'sh400000 * 128 * 255, 128));
        chk("rec2", rec_last[2], 24'h400000);
        chk("peak_full", src_peak[3], 24'h7FFFFF);
        chk("peak_neg", src_peak[4], 24'h400000);
        chk("opeak4", out_peak[4], 24'h3FC000);
        chk("opeak0", out_peak[0], 24'h07F800);
        $display("test saturate loopback done");
    endtask : t_sat
    initial begin
        repeat (8000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        rst = 1'b1;
        smp_valid = 1'b0;
        cfg_wr = 1'b0;
        cfg_sel = 2'h0;
        cfg_pair = 3'h0;
        cfg_src = 5'h00;
        cfg_val = 8'h00;
        loopback = '0;
        in_smp = '0;
        pb_data = '0;
        frame_en = 1'b0;
        n_fail = 0;
        checks_done = 0;
        t_reset();
        t_route();
        t_pairs();
        t_sat();
        test_done();
    end
endmodule : tb_matrix_mixer_with_metering
`default_nettype wire
